// >>> logic/udt_cfg.svh
// constants of the up/down timer core: offsets, field positions, resets
// assumes a 32-bit apb bus with byte addresses on an 8-bit paddr
`ifndef UDT_CFG_SVH
`define UDT_CFG_SVH
// register byte offsets
`define UDT_OFS_CTRL 8'h00
`define UDT_OFS_DIVX 8'h04
`define UDT_OFS_COUNT 8'h08
`define UDT_OFS_PERIOD 8'h0c
`define UDT_OFS_STAT 8'h10
// main control word fields
`define UDT_SRC_LSB 0
`define UDT_PSF_LSB 2
`define UDT_MODE_LSB 4
`define UDT_CLR_BIT 6
// status word fields
`define UDT_ROLL_BIT 0
`define UDT_MATCH_BIT 1
`define UDT_DIR_BIT 2
// reset values
`define UDT_RST_CTRL 6'h00
`define UDT_RST_DIVX 3'h0
`define UDT_RST_COUNT 16'h0000
`define UDT_RST_PERIOD 16'h0000
`define UDT_RST_DIV 3'h0
// count limits
`define UDT_CNT_MAX 16'hffff
`define UDT_CNT_ONE 16'h0001
`endif

// >>> logic/udt_pkg.sv
// types of the up/down timer core: count modes and clock sources
// assumes udt_cfg.svh supplies the numeric constants
package udt_pkg;
  // count mode field encodings
  typedef enum logic [1:0]
  {
    UDT_STOP = 2'b00,
    UDT_UP = 2'b01,
    UDT_CONT = 2'b10,
    UDT_UPDN = 2'b11
  } udt_mode_type;
  // clock source field encodings
  typedef enum logic [1:0]
  {
    UDT_SRC_AUX = 2'b00,
    UDT_SRC_SUBSYS = 2'b01,
    UDT_SRC_PIN = 2'b10,
    UDT_SRC_ALT = 2'b11
  } udt_src_type;
endpackage : udt_pkg

// >>> logic/udt_core.sv
// up/down timer core: source select, two prescalers, 16-bit counter, apb regs
// assumes clock sources arrive asynchronously and are sampled on clk
//
// Decided for this implementation: the APB slave port and the address map.
`timescale 1ns/1ps
`include "udt_cfg.svh"

module udt_core
(
  input wire logic clk,
  input wire logic rst,
  input wire logic auxClk,
  input wire logic subsysClk,
  input wire logic extClkPin,
  input wire logic altClk,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [15:0] countValue,
  output logic [15:0] periodValue,
  output logic rolloverFlag,
  output logic periodMatchFlag,
  output logic countDown,
  output logic countTick
);

  // register state
  logic [5:0] ctrl_ff; // source, first prescale, mode
  logic [2:0] divx_ff; // second prescale field
  logic [15:0] count_ff; // count value
  logic [15:0] period_ff; // period register
  logic roll_ff; // sticky rollover flag
  logic match_ff; // sticky period match flag
  logic down_ff; // latched count direction
  logic [2:0] div1_ff; // first prescaler down counter
  logic [2:0] div2_ff; // second prescaler down counter
  logic [31:0] rdata_ff; // read data captured in setup phase
  // next values
  logic [15:0] nxt_count;
  logic nxt_down;
  logic setRoll;
  logic setMatch;

  // source synchroniser inputs and outputs
  logic [3:0] rawSrc;
  logic [3:0] srcRise;
  // bus decode
  wire accessPhase = psel & penable;
  wire setupPhase = psel & ~penable;
  wire hitCtrl = (paddr == `UDT_OFS_CTRL);
  wire hitDivx = (paddr == `UDT_OFS_DIVX);
  wire hitCount = (paddr == `UDT_OFS_COUNT);
  wire hitPeriod = (paddr == `UDT_OFS_PERIOD);
  wire hitStat = (paddr == `UDT_OFS_STAT);
  wire hitAny = hitCtrl | hitDivx | hitCount | hitPeriod | hitStat;
  wire wrEn = accessPhase & pwrite & hitAny;
  wire wrCtrl = wrEn & hitCtrl;
  wire wrDivx = wrEn & hitDivx;
  wire wrCount = wrEn & hitCount;
  wire wrPeriod = wrEn & hitPeriod;
  wire wrStat = wrEn & hitStat;
  // clear is a self-clearing command, never stored
  wire clearReq = wrCtrl & pwdata[`UDT_CLR_BIT];
  wire clrRoll = wrStat & pwdata[`UDT_ROLL_BIT];
  wire clrMatch = wrStat & pwdata[`UDT_MATCH_BIT];

  // field selection
  udt_pkg::udt_mode_type modeSel;
  assign modeSel = udt_pkg::udt_mode_type'(ctrl_ff[`UDT_MODE_LSB +: 2]);
  wire [1:0] srcSel = ctrl_ff[`UDT_SRC_LSB +: 2];
  wire [1:0] psfSel = ctrl_ff[`UDT_PSF_LSB +: 2];
  wire run = (modeSel != udt_pkg::UDT_STOP);

  // first prescaler reload: ratio minus one for 1, 2, 4, 8
  wire [2:0] load1 = (psfSel == 2'b00) ? 3'h0 :
                     (psfSel == 2'b01) ? 3'h1 :
                     (psfSel == 2'b10) ? 3'h3 : 3'h7;
  // second prescaler reload: code n divides by n plus one
  wire [2:0] load2 = divx_ff;

  assign rawSrc = {altClk, extClkPin, subsysClk, auxClk};
  // one synchroniser and edge finder per clock source
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1)
    begin : gSync
      logic sync1_ff; // read only by sync2_ff
      logic sync2_ff;
      logic sync3_ff;
      logic stable_ff; // last agreed level
      // three stages; a level counts once stages two and three agree
      always_ff @(posedge clk)
      begin
        if (rst)
        begin
          sync1_ff <= 1'b0;
          sync2_ff <= 1'b0;
          sync3_ff <= 1'b0;
          stable_ff <= 1'b0;
        end
        else
        begin
          sync1_ff <= rawSrc[gi];
          sync2_ff <= sync1_ff;
          sync3_ff <= sync2_ff;
          if (sync2_ff == sync3_ff)
            stable_ff <= sync3_ff;
        end
      end
      // rising edge once the agreed level goes high
      assign srcRise[gi] = (sync2_ff == sync3_ff) & sync3_ff & ~stable_ff;
    end
  endgenerate

  // selected source edge, the slow rate is an enable, not a clock
  wire srcTick = srcRise[srcSel] & run;
  // a zero prescaler state fires at once, so the first edge ticks
  wire div1Tick = srcTick & (div1_ff == 3'h0);
  assign countTick = div1Tick & (div2_ff == 3'h0);

  // prescaler down counters
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      div1_ff <= `UDT_RST_DIV;
      div2_ff <= `UDT_RST_DIV;
    end
    else if (clearReq)
    begin
      div1_ff <= `UDT_RST_DIV;
      div2_ff <= `UDT_RST_DIV;
    end
    else
    begin
      if (srcTick)
        div1_ff <= (div1_ff == 3'h0) ? load1 : div1_ff - 3'h1;
      if (div1Tick)
        div2_ff <= (div2_ff == 3'h0) ? load2 : div2_ff - 3'h1;
    end
  end

  // counter step per mode; flags only come from real counting
  always_comb
  begin
    nxt_count = count_ff;
    nxt_down = down_ff;
    setRoll = 1'b0;
    setMatch = 1'b0;
    if (countTick)
    begin
      case (modeSel)
        udt_pkg::UDT_UP:
        begin
          // at or above period restart at zero, one roll flag only at period
          if (count_ff >= period_ff)
          begin
            nxt_count = 16'h0000;
            setRoll = (count_ff == period_ff);
          end
          else
          begin
            nxt_count = count_ff + `UDT_CNT_ONE;
            setMatch = (nxt_count == period_ff);
          end
        end
        udt_pkg::UDT_CONT:
        begin
          // free run, period acts as a plain match value
          nxt_count = count_ff + `UDT_CNT_ONE;
          setRoll = (count_ff == `UDT_CNT_MAX);
          setMatch = (nxt_count == period_ff);
        end
        udt_pkg::UDT_UPDN:
        begin
          if (!down_ff)
          begin
            // turning point; zero period stays parked at zero
            if (count_ff >= period_ff)
            begin
              if (count_ff != 16'h0000)
              begin
                nxt_down = 1'b1;
                nxt_count = count_ff - `UDT_CNT_ONE;
              end
            end
            else
            begin
              nxt_count = count_ff + `UDT_CNT_ONE;
              setMatch = (nxt_count == period_ff);
            end
          end
          else
          begin
            if (count_ff == `UDT_CNT_ONE)
            begin
              nxt_count = 16'h0000;
              nxt_down = 1'b0;
              setRoll = 1'b1;
            end
            else if (count_ff == 16'h0000)
              nxt_down = 1'b0;
            else
              nxt_count = count_ff - `UDT_CNT_ONE;
          end
        end
        default:
          nxt_count = count_ff; // stop holds everything
      endcase
    end
  end

  // count and direction; clear beats a software load beats counting
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      count_ff <= `UDT_RST_COUNT;
      down_ff <= 1'b0;
    end
    else if (clearReq)
    begin
      count_ff <= `UDT_RST_COUNT;
      down_ff <= 1'b0;
    end
    else
    begin
      count_ff <= wrCount ? pwdata[15:0] : nxt_count;
      down_ff <= nxt_down;
    end
  end

  // sticky flags; a set in the clearing cycle wins
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      roll_ff <= 1'b0;
      match_ff <= 1'b0;
    end
    else
    begin
      roll_ff <= setRoll | (roll_ff & ~clrRoll);
      match_ff <= setMatch | (match_ff & ~clrMatch);
    end
  end

  // configuration registers; ratios survive the clear
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ctrl_ff <= `UDT_RST_CTRL;
      divx_ff <= `UDT_RST_DIVX;
      period_ff <= `UDT_RST_PERIOD;
    end
    else
    begin
      if (wrCtrl)
        ctrl_ff <= pwdata[5:0];
      if (wrDivx)
        divx_ff <= pwdata[2:0];
      if (wrPeriod)
        period_ff <= pwdata[15:0];
    end
  end

  // read mux, captured in setup so prdata comes from a flop
  wire [31:0] rdMux = hitCtrl ? {26'h0, ctrl_ff} :
                      hitDivx ? {29'h0, divx_ff} :
                      hitCount ? {16'h0, count_ff} :
                      hitPeriod ? {16'h0, period_ff} :
                      hitStat ? {29'h0, down_ff, match_ff, roll_ff} : 32'h0;

  // read data register
  always_ff @(posedge clk)
  begin
    if (rst)
      rdata_ff <= 32'h0;
    else if (setupPhase)
      rdata_ff <= rdMux;
  end

  // zero wait state slave; unmapped addresses answer with an error
  assign pready = 1'b1;
  assign pslverr = accessPhase & ~hitAny;
  assign prdata = rdata_ff;
  assign countValue = count_ff;
  assign periodValue = period_ff;
  assign rolloverFlag = roll_ff;
  assign periodMatchFlag = match_ff;
  assign countDown = down_ff;

  // checks on the counter and prescalers
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  chk_stop_holds: assert property (
    (modeSel == udt_pkg::UDT_STOP) && !clearReq && !wrCount |=> $stable(count_ff))
    else $error("count moved while stopped");
  chk_up_wrap: assert property (
    countTick && modeSel == udt_pkg::UDT_UP && count_ff == period_ff
    && !wrCount && !clearReq |=> count_ff == 16'h0000 && roll_ff)
    else $error("up mode wrap wrong");
  chk_up_step: assert property (
    countTick && modeSel == udt_pkg::UDT_UP && count_ff + 16'h0001 == period_ff
    && count_ff < period_ff && !wrCount && !clearReq |=> match_ff && count_ff == period_ff)
    else $error("up mode match missing");
  chk_cont_wrap: assert property (
    countTick && modeSel == udt_pkg::UDT_CONT && count_ff == 16'hffff
    && !wrCount && !clearReq |=> count_ff == 16'h0000 && roll_ff)
    else $error("continuous wrap wrong");
  chk_updn_bottom: assert property (
    countTick && modeSel == udt_pkg::UDT_UPDN && down_ff && count_ff == 16'h0001
    && !wrCount && !clearReq |=> count_ff == 16'h0000 && roll_ff && !down_ff)
    else $error("up/down bottom wrong");
  chk_clear_all: assert property (
    clearReq |=> count_ff == 16'h0000 && !down_ff && div1_ff == 3'h0 && div2_ff == 3'h0)
    else $error("clear incomplete");
  // a source edge with both prescalers at zero must step the count itself
  chk_first_tick: assert property (
    srcTick && div1_ff == 3'h0 && div2_ff == 3'h0 && modeSel == udt_pkg::UDT_CONT
    && !wrCount && !clearReq |=> count_ff == $past(count_ff) + 16'h0001)
    else $error("first edge gave no tick");
  chk_div1_reload: assert property (
    div1Tick && !clearReq |=> div1_ff == $past(load1))
    else $error("first prescaler reload wrong");
  chk_div2_reload: assert property (
    countTick && !clearReq |=> div2_ff == $past(load2))
    else $error("second prescaler reload wrong");
  chk_load_noflag: assert property (
    wrCount && !countTick && !roll_ff && !match_ff |=> !roll_ff && !match_ff)
    else $error("load raised a flag");
  cov_up_roll: cover property (countTick && modeSel == udt_pkg::UDT_UP && setRoll);
  cov_updn_turn: cover property (countTick && modeSel == udt_pkg::UDT_UPDN && nxt_down
    && !down_ff);
  cov_cont_roll: cover property (countTick && modeSel == udt_pkg::UDT_CONT && setRoll);

endmodule : udt_core

// >>> verif/udt_src_model.sv
// far side of the timer core: four free-running clock sources
// assumes clk is the core clock; every source edge lands just after a clk edge
`timescale 1ns/1ps

module udt_src_model
#(
  parameter int HALF_AUX = 3, // half period of each source, in clk cycles
  parameter int HALF_SUB = 4,
  parameter int HALF_PIN = 5,
  parameter int HALF_ALT = 6
)
(
  input wire logic clk,
  input wire logic rst,
  output logic auxClk,
  output logic subsysClk,
  output logic extClkPin,
  output logic altClk
);
  // distinct rates let the bench tell the selected source by its tick spacing
  localparam int HALF [4] = '{HALF_AUX, HALF_SUB, HALF_PIN, HALF_ALT};
  logic [3:0] level_ff; // current level of each source
  int cnt_ff [4]; // cycles spent in the current half period

  // toggle each source every HALF cycles; halves of 3 or more keep the
  // core's two-cycle minimum high and low time with margin
  always_ff @(posedge clk)
  begin
    for (int i = 0; i < 4; i++)
    begin
      if (rst || cnt_ff[i] == HALF[i] - 1)
      begin
        cnt_ff[i] <= 0;
        level_ff[i] <= rst ? 1'b0 : ~level_ff[i];
      end
      else
      begin
        cnt_ff[i] <= cnt_ff[i] + 1;
      end
    end
  end

  assign auxClk = level_ff[0];
  assign subsysClk = level_ff[1];
  assign extClkPin = level_ff[2];
  assign altClk = level_ff[3];
endmodule : udt_src_model

// >>> verif/udt_tb.sv
// self-checking bench of the timer core: apb tasks and mode sequences
// assumes the core answers with zero wait states and clk runs at 200 MHz
`timescale 1ns/1ps
`include "udt_cfg.svh"

module tb;
  localparam int HALF [4] = '{3, 4, 5, 6}; // source half periods
  logic clk, rst, psel, penable, pwrite, pready, pslverr, errSeen;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic auxClk, subsysClk, extClkPin, altClk;
  logic rolloverFlag, periodMatchFlag, countDown, countTick;
  logic [15:0] countValue, periodValue;
  int failCount, totalChecks, g;

  udt_core dut (.clk(clk), .rst(rst), .auxClk(auxClk), .subsysClk(subsysClk),
    .extClkPin(extClkPin), .altClk(altClk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .countValue(countValue), .periodValue(periodValue),
    .rolloverFlag(rolloverFlag), .periodMatchFlag(periodMatchFlag),
    .countDown(countDown), .countTick(countTick));
  udt_src_model #(.HALF_AUX(HALF[0]), .HALF_SUB(HALF[1]), .HALF_PIN(HALF[2]),
    .HALF_ALT(HALF[3])) src (.clk(clk), .rst(rst), .auxClk(auxClk),
    .subsysClk(subsysClk), .extClkPin(extClkPin), .altClk(altClk));

  // 5 ns clock
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // compare and count; x never matches
  task check(input logic [31:0] seen, input logic [31:0] exp);
    totalChecks++;
    if (seen !== exp)
    begin
      failCount++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check

  // one apb transfer: setup, access until pready, then release
  task apb(input logic wr, input logic [7:0] addr, input logic [31:0] wdata);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wdata;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1)
      failCount++;
    rdata = prdata;
    errSeen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task rd(input logic [7:0] addr, input logic [31:0] exp);
    apb(1'b0, addr, 32'h0);
    check(rdata, exp);
  endtask : rd

  // control word from its fields
  function automatic logic [31:0] ctl(input int src, input int psf, input int mode,
    input int clr);
    return 32'((src << `UDT_SRC_LSB) | (psf << `UDT_PSF_LSB) | (mode << `UDT_MODE_LSB)
      | (clr << `UDT_CLR_BIT));
  endfunction : ctl

  // wait for n ticks; returns just after the edge where the count moved
  task waitTicks(input int n);
    int k;
    repeat (n)
    begin
      k = 0;
      do
      begin
        @(posedge clk);
        k++;
      end
      while (countTick !== 1'b1 && k < 3000);
      // a tick that never comes counts as a mismatch
      if (countTick !== 1'b1)
        failCount++;
    end
    #1;
  endtask : waitTicks

  // cycles between two ticks, skipping the start-up ones
  task gapOf;
    waitTicks(2);
    g = 0;
    do
    begin
      @(posedge clk);
      g++;
    end
    while (countTick !== 1'b1 && g < 3000);
    if (countTick !== 1'b1)
      failCount++;
  endtask : gapOf

  // start sequence: clear in stop, count, period, divider, flags, mode
  task setRun(input int src, input int psf, input int dx, input int mode,
    input logic [31:0] cnt, input logic [31:0] per);
    apb(1'b1, `UDT_OFS_CTRL, ctl(src, psf, 0, 1));
    apb(1'b1, `UDT_OFS_COUNT, cnt);
    apb(1'b1, `UDT_OFS_PERIOD, per);
    apb(1'b1, `UDT_OFS_DIVX, 32'(dx));
    apb(1'b1, `UDT_OFS_STAT, 32'h3);
    apb(1'b1, `UDT_OFS_CTRL, ctl(src, psf, mode, 0));
  endtask : setRun

  task endTest(input string name);
    $display("test %s done, %0d mismatches so far", name, failCount);
  endtask : endTest

  task conclude;
    $display("checks %0d, mismatches %0d", totalChecks, failCount);
    if (failCount == 0 && totalChecks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : conclude

  // watchdog: the sequence needs well under 20000 cycles
  initial
  begin
    #250000;
    failCount++;
    conclude();
  end

  // main sequence
  initial
  begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    failCount = 0;
    totalChecks = 0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rd(`UDT_OFS_CTRL, 32'h0);
    rd(`UDT_OFS_DIVX, 32'h0);
    rd(`UDT_OFS_COUNT, 32'h0);
    rd(`UDT_OFS_PERIOD, 32'h0);
    rd(`UDT_OFS_STAT, 32'h0);
    apb(1'b0, 8'h14, 32'h0);
    check(errSeen, 1'b1);
    check(rdata, 32'h0);
    endTest("reset");
    // tick spacing follows the source and both dividers
    for (int s = 0; s < 4; s++)
    begin
      setRun(s, 0, 0, udt_pkg::UDT_CONT, 32'h0, 32'h0);
      gapOf();
      check(g, 2 * HALF[s]);
    end
    for (int p = 0; p < 4; p++)
    begin
      setRun(0, p, 0, udt_pkg::UDT_CONT, 32'h0, 32'h0);
      gapOf();
      check(g, (2 * HALF[0]) << p);
    end
    for (int d = 0; d < 8; d++)
    begin
      setRun(0, 1, d, udt_pkg::UDT_CONT, 32'h0, 32'h0);
      gapOf();
      check(g, 4 * HALF[0] * (d + 1));
    end
    endTest("prescale");
    // up mode to period 3
    setRun(0, 0, 7, udt_pkg::UDT_UP, 32'h0, 32'h3);
    check(periodValue, 16'h3);
    waitTicks(3);
    check(countValue, 16'h3);
    check({periodMatchFlag, rolloverFlag}, 2'b10);
    waitTicks(1);
    check(countValue, 16'h0);
    check({periodMatchFlag, rolloverFlag}, 2'b11);
    setRun(0, 0, 7, udt_pkg::UDT_STOP, 32'h0, 32'h3);
    apb(1'b1, `UDT_OFS_COUNT, 32'h3);
    rd(`UDT_OFS_STAT, 32'h0);
    apb(1'b1, `UDT_OFS_COUNT, 32'ha);
    apb(1'b1, `UDT_OFS_CTRL, ctl(0, 0, udt_pkg::UDT_UP, 0));
    waitTicks(1);
    check(countValue, 16'h0);
    apb(1'b1, `UDT_OFS_CTRL, ctl(0, 0, udt_pkg::UDT_STOP, 0));
    apb(1'b1, `UDT_OFS_COUNT, 32'h1);
    apb(1'b1, `UDT_OFS_CTRL, ctl(0, 0, udt_pkg::UDT_UP, 0));
    waitTicks(1);
    check(countValue, 16'h2);
    endTest("up");
    // continuous wrap
    setRun(0, 0, 7, udt_pkg::UDT_CONT, 32'hfffe, 32'h5);
    waitTicks(1);
    check({countValue, rolloverFlag}, {16'hffff, 1'b0});
    waitTicks(1);
    check({countValue, rolloverFlag}, {16'h0, 1'b1});
    endTest("continuous");
    // up/down to period 2, stop on the way down, resume
    setRun(0, 0, 7, udt_pkg::UDT_UPDN, 32'h0, 32'h2);
    waitTicks(2);
    check({countValue, periodMatchFlag, rolloverFlag}, {16'h2, 2'b10});
    waitTicks(1);
    check({countValue, countDown}, {16'h1, 1'b1});
    apb(1'b1, `UDT_OFS_CTRL, ctl(0, 0, udt_pkg::UDT_STOP, 0));
    repeat (200) @(posedge clk);
    check({countValue, countDown}, {16'h1, 1'b1});
    apb(1'b1, `UDT_OFS_CTRL, ctl(0, 0, udt_pkg::UDT_UPDN, 0));
    waitTicks(1);
    check({countValue, rolloverFlag}, {16'h0, 1'b1});
    setRun(0, 2, 7, udt_pkg::UDT_UPDN, 32'h5, 32'h3);
    waitTicks(1);
    check({countValue, countDown}, {16'h4, 1'b1});
    // clear while stopped on the way down at a nonzero count, so the clear has work to do
    apb(1'b1, `UDT_OFS_CTRL, ctl(0, 2, udt_pkg::UDT_STOP, 0));
    apb(1'b1, `UDT_OFS_CTRL, ctl(0, 2, udt_pkg::UDT_STOP, 1));
    #1;
    check({countValue, countDown}, {16'h0, 1'b0});
    rd(`UDT_OFS_DIVX, 32'h7);
    rd(`UDT_OFS_CTRL, ctl(0, 2, 0, 0));
    endTest("updown");
    conclude();
  end
endmodule : tb
